// *** pica_ctrl_access.sv ***
`timescale 1ns/1ps
module pica_ctrl_access import pica_pkg::*; #(
  // arbitrary neutral identification value
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  input  wire logic link_clk_in,
  input  wire logic link_data_in,
  output logic      link_data_out,
  output logic      link_data_oe_out,
  output logic      nvm_prog_enabled_out
);
  pica_state_t state_q;
  logic        rise;
  logic        sbit;
  logic        rx_busy_q;
  logic [3:0]  rx_cnt_q;
  logic [10:0] rx_sh_q;
  logic [10:0] frame;
  logic [7:0]  rx_data;
  logic        frame_done;
  logic        brk;
  logic        perr;
  logic        ferr;
  logic        good;
  logic        collide;
  logic        fault;
  logic        listen;
  logic        driving;
  logic [7:0]  op_q;
  logic [3:0]  ops_left_q;
  logic [8:0]  guard_cnt_q;
  logic [7:0]  tx_byte_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_cnt_q;
  logic [2:0]  guard_time_sel_q;
  logic        nvm_prog_enabled_q;
  logic [63:0] key_q;
  logic [63:0] key_full;
  logic        store_wr;
  logic        key_done;
  logic        key_match;

  // =====================================================================
  // helpers
  function automatic logic [8:0] guard_bits(input logic [2:0] sel);
    guard_bits = (sel == GUARD_ZERO_SEL) ? 9'h000 : (GUARD_MAX_BITS >> sel);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (!op[7] && op[4]) || op[7:4] == OP_LOAD_DS_HI ||
              op[7:4] == OP_LOAD_CS_HI;
  endfunction

  function automatic logic [7:0] css_read(input logic [3:0] a,
                                          input logic       en,
                                          input logic [2:0] gs);
    unique case (a)
      ADDR_STATUS: css_read = 8'(en) << ENABLED_BIT;
      ADDR_GUARD:  css_read = {5'h00, gs};
      ADDR_IDENT:  css_read = ID_CODE;
      default:     css_read = 8'h00;
    endcase
  endfunction

  pica_link_sampler u_sampler (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .ce_in        (ce_in),
    .link_clk_in  (link_clk_in),
    .link_data_in (link_data_in),
    .rise_out     (rise),
    .bit_out      (sbit)
  );

  // =====================================================================
  // frame receiver
  assign listen  = state_q == ST_IDLE || state_q == ST_OPER ||
                   state_q == ST_ERR;
  assign driving = state_q == ST_GUARD || state_q == ST_TX;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 4'h0;
      rx_sh_q   <= 11'h000;
    end else if (ce_in && rise) begin
      if (!listen) begin
        rx_busy_q <= 1'b0;
      end else if (rx_busy_q) begin
        rx_sh_q  <= {sbit, rx_sh_q[10:1]};
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == RX_LAST) begin
          rx_busy_q <= 1'b0;
        end
      end else if (!sbit) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 4'h0;
      end
    end
  end

  // a break is twelve low bits: start, all data, parity and both stops
  assign frame      = {sbit, rx_sh_q[10:1]};
  assign rx_data    = frame[7:0];
  assign frame_done = rise && listen && rx_busy_q && rx_cnt_q == RX_LAST;
  assign brk        = frame_done && frame == 11'h000;
  assign perr       = frame_done && !brk && frame[8] != ^rx_data;
  assign ferr       = frame_done && !brk && frame[10:9] != 2'b11;
  assign good       = frame_done && !brk && !perr && !ferr &&
                      state_q != ST_ERR;
  assign collide    = rise && driving && sbit != link_data_out;
  assign fault      = (brk && state_q != ST_ERR) || perr || ferr ||
                      collide;

  // =====================================================================
  // instruction sequencer and turnaround
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q          <= ST_IDLE;
      op_q             <= 8'h00;
      ops_left_q       <= 4'h0;
      guard_cnt_q      <= 9'h000;
      tx_byte_q        <= 8'h00;
      tx_sh_q          <= 11'h7FF;
      tx_cnt_q         <= 4'h0;
      link_data_out    <= 1'b1;
      link_data_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (fault) begin
        state_q          <= ST_ERR;
        link_data_oe_out <= 1'b0;
        link_data_out    <= 1'b1;
      end else if (brk) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: if (good) begin
            op_q <= rx_data;
            if (is_read(rx_data)) begin
              // out-of-scope data-space reads answer zero
              tx_byte_q <= (rx_data[7:4] == OP_LOAD_CS_HI) ?
                           css_read(rx_data[3:0], nvm_prog_enabled_q,
                                    guard_time_sel_q) : 8'h00;
              guard_cnt_q      <= guard_bits(guard_time_sel_q) +
                                  TURN_EXTRA;
              state_q          <= ST_GUARD;
              link_data_oe_out <= 1'b1;
              link_data_out    <= 1'b1;
            end else begin
              ops_left_q <= (rx_data == OP_KEY) ? KEY_BYTES : 4'h1;
              state_q    <= ST_OPER;
            end
          end
          ST_OPER: if (good) begin
            ops_left_q <= ops_left_q - 4'h1;
            if (ops_left_q == 4'h1) begin
              state_q <= ST_IDLE;
            end
          end
          ST_GUARD: if (rise) begin
            guard_cnt_q <= guard_cnt_q - 9'h001;
            if (guard_cnt_q == 9'h001) begin
              tx_sh_q       <= {2'b11, ^tx_byte_q, tx_byte_q};
              tx_cnt_q      <= 4'h0;
              link_data_out <= 1'b0;
              state_q       <= ST_TX;
            end
          end
          ST_TX: if (rise) begin
            if (tx_cnt_q == TX_LAST) begin
              // back to receive at once, no extra idle
              link_data_oe_out <= 1'b0;
              state_q          <= ST_IDLE;
            end else begin
              link_data_out <= tx_sh_q[0];
              tx_sh_q       <= {1'b1, tx_sh_q[10:1]};
              tx_cnt_q      <= tx_cnt_q + 4'h1;
            end
          end
          ST_ERR: ;
        endcase
      end
    end
  end

  // =====================================================================
  // control space registers and key check
  assign store_wr  = good && state_q == ST_OPER &&
                     op_q[7:4] == OP_STORE_CS_HI;
  assign key_full  = {rx_data, key_q[63:8]};
  assign key_done  = good && state_q == ST_OPER && op_q == OP_KEY &&
                     ops_left_q == 4'h1;
  assign key_match = key_full == UNLOCK_KEY;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      key_q <= 64'h0000_0000_0000_0000;
    end else if (ce_in && good && state_q == ST_OPER && op_q == OP_KEY) begin
      key_q <= key_full;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      nvm_prog_enabled_q <= 1'b0;
    end else if (ce_in) begin
      if (key_done && key_match) begin
        nvm_prog_enabled_q <= 1'b1;
      end else if (store_wr && op_q[3:0] == ADDR_STATUS &&
                   !rx_data[ENABLED_BIT]) begin
        nvm_prog_enabled_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      guard_time_sel_q <= GUARD_RESET;
    end else if (ce_in && store_wr && op_q[3:0] == ADDR_GUARD) begin
      guard_time_sel_q <= rx_data[2:0];
    end
  end

  assign nvm_prog_enabled_out = nvm_prog_enabled_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in || !ce_in);

  sequence s_load_cs;
    good && state_q == ST_IDLE && rx_data[7:4] == OP_LOAD_CS_HI;
  endsequence

  a_load_returns_byte: assert property (
    s_load_cs |=> state_q == ST_GUARD &&
    tx_byte_q == css_read($past(rx_data[3:0]), nvm_prog_enabled_q,
                          guard_time_sel_q))
    else $error("load did not capture addressed byte");
  a_store_sets_guard: assert property (
    store_wr && op_q[3:0] == ADDR_GUARD
    |=> guard_time_sel_q == $past(rx_data[2:0]))
    else $error("guard store not applied");
  a_enable_needs_key: assert property (
    $rose(nvm_prog_enabled_q) |-> $past(key_done && key_match))
    else $error("programming enabled without full key");
  a_bad_key_off: assert property (
    key_done && !key_match && !nvm_prog_enabled_q |=> !nvm_prog_enabled_q)
    else $error("wrong key enabled programming");
  a_zero_disables: assert property (
    store_wr && op_q[3:0] == ADDR_STATUS && !rx_data[ENABLED_BIT]
    |=> !nvm_prog_enabled_q)
    else $error("zero write did not disable");
  a_reserved_zero: assert property (
    s_load_cs ##1
    ($past(rx_data[3:0]) != ADDR_STATUS && $past(rx_data[3:0]) != ADDR_GUARD
     && $past(rx_data[3:0]) != ADDR_IDENT) |-> tx_byte_q == 8'h00)
    else $error("reserved address read nonzero");
  a_guard_length: assert property (
    s_load_cs |=> guard_cnt_q == guard_bits(guard_time_sel_q) + TURN_EXTRA)
    else $error("turnaround idle length wrong");
  a_tx_release: assert property (
    state_q == ST_TX && rise && tx_cnt_q == TX_LAST && !fault
    |=> !link_data_oe_out && state_q == ST_IDLE)
    else $error("transmit did not release the line");
  a_fault_error: assert property (
    fault |=> (state_q == ST_ERR && !link_data_oe_out) [*2])
    else $error("fault did not enter error state");
  a_guard_default: assert property (
    $past(!resetn_in) |-> guard_time_sel_q == GUARD_RESET)
    else $error("guard field not at default after reset");
endmodule

// *** pica_pkg.sv ***
package pica_pkg;
  // =====================================================================
  // instruction codes
  localparam logic [3:0] OP_LOAD_CS_HI  = 4'h8;
  localparam logic [3:0] OP_STORE_CS_HI = 4'hC;
  localparam logic [3:0] OP_LOAD_DS_HI  = 4'h2;
  localparam logic [7:0] OP_KEY         = 8'hE0;
  localparam logic [3:0] KEY_BYTES      = 4'h8;
  // =====================================================================
  // control space map and fields
  localparam logic [3:0] ADDR_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_GUARD     = 4'h2;
  localparam logic [3:0] ADDR_IDENT     = 4'hF;
  localparam int         ENABLED_BIT    = 1;
  localparam logic [2:0] GUARD_RESET    = 3'h0;
  localparam logic [2:0] GUARD_ZERO_SEL = 3'h7;
  localparam logic [8:0] GUARD_MAX_BITS = 9'h080;
  localparam logic [8:0] TURN_EXTRA     = 9'h002;
  localparam logic [63:0] UNLOCK_KEY    = 64'h1289_AB45_CDD8_88FF;
  // =====================================================================
  // frame layout: start, 8 data, even parity, 2 stop
  localparam logic [3:0] RX_LAST        = 4'hA;
  localparam logic [3:0] TX_LAST        = 4'hB;
  // =====================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPER  = 3'b001,
    ST_GUARD = 3'b010,
    ST_TX    = 3'b011,
    ST_ERR   = 3'b100
  } pica_state_t;
endpackage

// *** pica_link_sampler.sv ***
`timescale 1ns/1ps
module pica_link_sampler (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  input  wire logic link_clk_in,
  input  wire logic link_data_in,
  output logic      rise_out,
  output logic      bit_out
);
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic dat_s1_q;
  logic dat_s2_q;

  // =====================================================================
  // two-flop synchronisers; clock and data share the same delay
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else if (ce_in) begin
      clk_s1_q <= link_clk_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= link_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rise_out <= 1'b0;
      bit_out  <= 1'b1;
    end else if (ce_in) begin
      rise_out <= clk_s2_q & ~clk_s3_q;
      bit_out  <= dat_s2_q;
    end
  end
endmodule

// *** pica_prog_model.sv ***
`timescale 1ns/1ps
module pica_prog_model (
  input  wire logic clk_in,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  output logic      link_clk_out,
  output logic      link_wire_out
);
  logic prog_drv;
  // open-drain style wire: a released party leaves it to the pull-up
  assign link_wire_out = prog_drv & (dev_oe_in ? dev_data_in : 1'b1);
  initial begin
    link_clk_out = 1'b0;
    prog_drv = 1'b1;
  end
  // =====================================================================
  // bit level: data moves while the link clock is low, never between
  // frames, so the clock stands still outside the tasks
  task automatic put_bit(input logic b, output logic s);
    prog_drv = b;
    repeat (4) @(negedge clk_in);
    s = link_wire_out;
    link_clk_out = 1'b1;
    repeat (4) @(negedge clk_in);
    link_clk_out = 1'b0;
  endtask
  // =====================================================================
  // frames
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic s;
    put_bit(1'b0, s);
    for (int i = 0; i < 8; i++) put_bit(b[i], s);
    put_bit(^b ^ bad_par, s);
    put_bit(1'b1, s);
    put_bit(1'b1, s);
  endtask
  task automatic send_break();
    logic s;
    repeat (12) put_bit(1'b0, s);
    put_bit(1'b1, s);
  endtask
  task automatic send_key(input logic [63:0] k);
    send_byte(8'hE0, 1'b0);
    for (int i = 0; i < 8; i++) send_byte(k[8*i +: 8], 1'b0);
  endtask
  // line released: counts idle bits before the start bit, bounded
  task automatic recv(output logic [7:0] b, output logic [8:0] idle,
                      output logic ok);
    logic       s;
    logic [2:0] tail;
    idle = 9'h000;
    put_bit(1'b1, s);
    while (s === 1'b1 && idle < 9'h0C8) begin
      idle = idle + 9'h001;
      put_bit(1'b1, s);
    end
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    for (int i = 0; i < 3; i++) begin
      put_bit(1'b1, s);
      tail[i] = s;
    end
    // clock left standing: the device must have released the line by now
    ok = (tail === {2'b11, ^b});
  endtask
endmodule

// *** tb_pica_ctrl_access.sv ***
`timescale 1ns/1ps
module tb_pica_ctrl_access;
  import pica_pkg::*;
  // arbitrary identification value
  localparam logic [7:0] ID = 8'h3C;
  logic       clk_in;
  logic       resetn_in;
  logic       ce_in;
  logic       link_clk;
  logic       wire_lvl;
  logic       dev_d;
  logic       dev_oe;
  logic       en;
  logic       s;
  logic [2:0] cur_sel;
  int         fail_count;
  int         n_tests;

  pica_ctrl_access #(.ID_CODE(ID)) dut_u (
    .clk_in               (clk_in),
    .resetn_in            (resetn_in),
    .ce_in                (ce_in),
    .link_clk_in          (link_clk),
    .link_data_in         (wire_lvl),
    .link_data_out        (dev_d),
    .link_data_oe_out     (dev_oe),
    .nvm_prog_enabled_out (en)
  );
  pica_prog_model prog_u (
    .clk_in        (clk_in),
    .dev_data_in   (dev_d),
    .dev_oe_in     (dev_oe),
    .link_clk_out  (link_clk),
    .link_wire_out (wire_lvl)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // =====================================================================
  // checking and access tasks
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // extra idle bits for each guard select code
  function automatic logic [8:0] gbits(input logic [2:0] sel);
    logic [8:0] g;
    case (sel)
      3'h0: g = 9'h080;
      3'h1: g = 9'h040;
      3'h2: g = 9'h020;
      3'h3: g = 9'h010;
      3'h4: g = 9'h008;
      3'h5: g = 9'h004;
      3'h6: g = 9'h002;
      default: g = 9'h000;
    endcase
    return g;
  endfunction
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rd_op({OP_LOAD_CS_HI, a}, exp);
  endtask
  task automatic rd_op(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] b;
    logic [8:0] idle;
    logic       ok;
    prog_u.send_byte(op, 1'b0);
    prog_u.recv(b, idle, ok);
    check({1'b0, b}, {1'b0, exp});
    check(idle, gbits(cur_sel) + 9'h002);
    check({8'h00, ok}, 9'h001);
    repeat (4) @(negedge clk_in);
    check({8'h00, dev_oe}, 9'h000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    prog_u.send_byte({OP_STORE_CS_HI, a}, 1'b0);
    prog_u.send_byte(d, 1'b0);
    if (a == ADDR_GUARD) cur_sel = d[2:0];
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // =====================================================================
  // sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    ce_in = 1'b1;
    resetn_in = 1'b0;
    cur_sel = 3'h0;
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge clk_in);
    check({8'h00, dev_oe}, 9'h000);
    check({8'h00, en}, 9'h000);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_IDENT, ID);
    rd(ADDR_GUARD, 8'h00);
    // ends on the shortest guard time, which also keeps the run short
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_GUARD, {5'h1F, 3'(i)});
      rd(ADDR_GUARD, {5'h00, 3'(i)});
    end
    wr(ADDR_IDENT, 8'h00);
    rd(ADDR_IDENT, ID);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h00);
    rd(4'hE, 8'h00);
    // data-space read answers zero; a write form eats exactly one operand
    rd_op(8'h20, 8'h00);
    prog_u.send_byte(8'h68, 1'b0);
    prog_u.send_byte(8'h55, 1'b0);
    rd(ADDR_IDENT, ID);
    prog_u.send_key(64'h1289_AB45_CDD8_88FE);
    check({8'h00, en}, 9'h000);
    rd(ADDR_STATUS, 8'h00);
    prog_u.send_key(64'h1289_AB45_CDD8_88FF);
    rd(ADDR_STATUS, 8'h02);
    check({8'h00, en}, 9'h001);
    // clock enable low with the link quiet must hold every register
    ce_in = 1'b0;
    repeat (10) @(negedge clk_in);
    check({8'h00, en}, 9'h001);
    check({8'h00, dev_oe}, 9'h000);
    ce_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rd(ADDR_STATUS, 8'h02);
    wr(ADDR_STATUS, 8'hFD);
    rd(ADDR_STATUS, 8'h00);
    check({8'h00, en}, 9'h000);
    // bad parity: the following read must go unanswered
    prog_u.send_byte({OP_LOAD_CS_HI, ADDR_IDENT}, 1'b1);
    prog_u.send_byte({OP_LOAD_CS_HI, ADDR_IDENT}, 1'b0);
    repeat (6) prog_u.put_bit(1'b1, s);
    check({8'h00, dev_oe}, 9'h000);
    prog_u.send_break();
    rd(ADDR_IDENT, ID);
    // pull the line low while the device drives its idle bits
    prog_u.send_byte({OP_LOAD_CS_HI, ADDR_STATUS}, 1'b0);
    prog_u.put_bit(1'b0, s);
    repeat (3) prog_u.put_bit(1'b1, s);
    check({8'h00, dev_oe}, 9'h000);
    prog_u.send_break();
    rd(ADDR_GUARD, 8'h07);
    summarize();
  end

  initial begin
    #1200000;
    fail_count++;
    summarize();
  end
endmodule
